// ==== core/synth_cfg_pkg.sv ====
package synth_cfg_pkg;
   // bus geometry
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int NUM_SETS = 4;
   // ratio word: 12 integer bits, 20 fraction bits
   localparam int RATIO_W = 32;
   localparam int RATIO_INT_W = 12;
   localparam int RATIO_FRAC_W = 20;
   localparam int SYNC_W = 6;

   // register offsets (byte addresses, one word each)
   localparam logic [7:0] OFS_RATIO0 = 8'h00;
   localparam logic [7:0] OFS_MODAL0 = 8'h10;
   localparam logic [7:0] OFS_GLOBAL = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_EFFRATIO = 8'h28;

   // modal select word fields
   localparam int MODAL_RMOD_LSB = 0;
   localparam int MODAL_AUX_LSB = 2;
   // global word fields
   localparam int GLB_FN_LSB = 0;
   localparam int GLB_UNL_BIT = 3;
   localparam int GLB_DIV_LSB = 4;
   localparam int GLB_LOCKCFG_BIT = 6;
   // status word fields
   localparam int STS_LOCK_BIT = 0;
   localparam int STS_PIN_BIT = 1;
   localparam int STS_MODE_LSB = 2;
   localparam int STS_AUX_LSB = 4;

   typedef enum logic [1:0] {
      DIV_BY4 = 2'b00,
      DIV_BY2 = 2'b01,
      DIV_BY1 = 2'b10,
      DIV_RSVD = 2'b11
   } ref_div_t;

   typedef enum logic [1:0] {
      AUX_REF = 2'b00,
      AUX_RSVD = 2'b01,
      AUX_MAIN = 2'b10,
      AUX_UNLOCK = 2'b11
   } aux_src_t;

   typedef enum logic [2:0] {
      FN_DIS_MAIN = 3'b000,
      FN_DIS_AUX = 3'b001,
      FN_DIS_BOTH = 3'b010,
      FN_RMOD_EN = 3'b011,
      FN_RSVD4 = 3'b100,
      FN_RSVD5 = 3'b101,
      FN_RSVD6 = 3'b110,
      FN_FORCE_AUX = 3'b111
   } pin_fn_t;

   // values after reset
   localparam logic [31:0] RST_RATIO = 32'h0010_0000;
   localparam logic [1:0] RST_RMOD = 2'h0;
   localparam aux_src_t RST_AUX = AUX_REF;
   localparam ref_div_t RST_DIV = DIV_BY1;
   localparam logic RST_UNL = 1'b0;
   localparam pin_fn_t RST_FN = FN_DIS_MAIN;
   localparam logic RST_LOCKCFG = 1'b0;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   // ratio modifier: codes 0..3 shift right by 1..4
   function automatic logic [31:0] ratio_modify(input logic [31:0] r, input logic [1:0] m);
      return r >> ({1'b0, m} + 3'h1);
   endfunction : ratio_modify
endpackage : synth_cfg_pkg

// ==== core/refdiv_if.sv ====
interface refdiv_if;
   logic [1:0] sel;
   logic ref_level;
   logic div_level;
   modport core (output sel, output ref_level, input div_level);
   modport divider (input sel, input ref_level, output div_level);
endinterface : refdiv_if

// ==== core/ref_divider.sv ====
// divides the synchronised reference level by 1, 2 or 4
module ref_divider (
   input wire logic clk_i,
   input wire logic rst_i,
   refdiv_if.divider dv
);
   import synth_cfg_pkg::*;

   logic prev_ref;
   logic [1:0] edge_cnt;
   logic div_q;
   logic rise;

   assign rise = dv.ref_level && !prev_ref;
   assign dv.div_level = div_q;

   // rising-edge counter of the reference level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_ref <= 1'b0;
         edge_cnt <= 2'h0;
      end else begin
         prev_ref <= dv.ref_level;
         if (rise) begin
            edge_cnt <= edge_cnt + 2'h1;
         end
      end
   end

   // divider select; the reserved code parks the output low rather than guess a ratio
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 1'b0;
      end else begin
         unique case (ref_div_t'(dv.sel))
            DIV_BY4: div_q <= edge_cnt[1];
            DIV_BY2: div_q <= edge_cnt[0];
            DIV_BY1: div_q <= dv.ref_level;
            DIV_RSVD: div_q <= 1'b0;
         endcase
      end
   end

   a_div_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      (dv.sel == DIV_BY1) |=> (div_q == $past(dv.ref_level)))
      else $error("divide-by-one output does not follow reference");
   a_div_half: assert property (@(posedge clk_i) disable iff (rst_i)
      (dv.sel == DIV_BY2) && $stable(dv.sel) && !rise && !$past(rise) |=> $stable(div_q))
      else $error("divide-by-two output moved without a reference edge");
endmodule : ref_divider

// ==== core/synth_global_config_control.sv ====
module synth_global_config_control (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [synth_cfg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [synth_cfg_pkg::DAT_W-1:0] wb_dat_i,
   output logic [synth_cfg_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] mode_select_i,
   input wire logic special_mode_pin_i,
   input wire logic pll_locked_i,
   input wire logic ref_clk_i,
   input wire logic pll_clk_i,
   output logic ref_div_clk_o,
   output logic clk_out_o,
   output logic aux_out_o,
   output logic aux_out_oe_o,
   output logic [synth_cfg_pkg::RATIO_W-1:0] ratio_o
);
   import synth_cfg_pkg::*;

   // modal and global sets
   logic [RATIO_W-1:0] ratio_set [NUM_SETS];
   logic [1:0] ratio_modifier_select [NUM_SETS];
   aux_src_t aux_source_select [NUM_SETS];
   ref_div_t reference_divider_select;
   logic output_on_unlock_enable;
   pin_fn_t special_pin_function;
   logic lock_indicator_config;

   // pin synchronisers
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [1:0] mode_s;
   logic pin_s;
   logic locked_s;
   logic ref_s;
   logic pll_s;

   // bus
   logic req;
   logic wr;
   logic [31:0] global_word;
   logic [31:0] status_word;
   logic [31:0] next_rdata;

   // output path
   aux_src_t aux_eff;
   logic main_dis;
   logic aux_dis;
   logic rmod_on;
   logic pll_gated;
   logic next_main;
   logic next_aux;
   logic next_aux_oe;
   logic [RATIO_W-1:0] next_ratio;

   refdiv_if dv ();

   ref_divider u_ref_divider (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dv(dv)
   );

   // every pin and foreign clock crosses two flops before any logic sees it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {mode_select_i, special_mode_pin_i, pll_locked_i, ref_clk_i, pll_clk_i};
         sync2 <= sync1;
      end
   end

   assign {mode_s, pin_s, locked_s, ref_s, pll_s} = sync2;

   assign dv.sel = reference_divider_select;
   assign dv.ref_level = ref_s;
   assign ref_div_clk_o = dv.div_level;

   // a request is taken once; ack drops the cycle after it is given
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;

   assign global_word = {25'h0, lock_indicator_config, reference_divider_select, output_on_unlock_enable,
                         special_pin_function};
   assign status_word = {26'h0, aux_eff, mode_s, pin_s, locked_s};

   // read mux; unmapped offsets read as zero and ignore writes
   always_comb begin
      next_rdata = 32'h0;
      for (int s = 0; s < NUM_SETS; s++) begin
         if (wb_adr_i == OFS_RATIO0 + 8'(4 * s)) begin
            next_rdata = ratio_set[s];
         end
         if (wb_adr_i == OFS_MODAL0 + 8'(4 * s)) begin
            next_rdata = {28'h0, aux_source_select[s], ratio_modifier_select[s]};
         end
      end
      if (wb_adr_i == OFS_GLOBAL) begin
         next_rdata = global_word;
      end
      if (wb_adr_i == OFS_STATUS) begin
         next_rdata = status_word;
      end
      if (wb_adr_i == OFS_EFFRATIO) begin
         next_rdata = ratio_o;
      end
   end

   // bus answer one cycle after the request edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   // four modal sets, written by byte lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int s = 0; s < NUM_SETS; s++) begin
            ratio_set[s] <= RST_RATIO;
            ratio_modifier_select[s] <= RST_RMOD;
            aux_source_select[s] <= RST_AUX;
         end
      end else begin
         for (int s = 0; s < NUM_SETS; s++) begin
            if (wr && wb_adr_i == OFS_RATIO0 + 8'(4 * s)) begin
               ratio_set[s] <= lane_merge(ratio_set[s], wb_dat_i, wb_sel_i);
            end
            if (wr && wb_adr_i == OFS_MODAL0 + 8'(4 * s) && wb_sel_i[0]) begin
               ratio_modifier_select[s] <= wb_dat_i[MODAL_RMOD_LSB +: 2];
               aux_source_select[s] <= aux_src_t'(wb_dat_i[MODAL_AUX_LSB +: 2]);
            end
         end
      end
   end

   // global set: applies to whichever modal set the mode pins pick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reference_divider_select <= RST_DIV;
         output_on_unlock_enable <= RST_UNL;
         special_pin_function <= RST_FN;
         lock_indicator_config <= RST_LOCKCFG;
      end else if (wr && wb_adr_i == OFS_GLOBAL && wb_sel_i[0]) begin
         special_pin_function <= pin_fn_t'(wb_dat_i[GLB_FN_LSB +: 3]);
         output_on_unlock_enable <= wb_dat_i[GLB_UNL_BIT];
         reference_divider_select <= ref_div_t'(wb_dat_i[GLB_DIV_LSB +: 2]);
         lock_indicator_config <= wb_dat_i[GLB_LOCKCFG_BIT];
      end
   end

   // special pin decode; reserved functions fall through to no effect
   always_comb begin
      main_dis = 1'b0;
      aux_dis = 1'b0;
      rmod_on = 1'b0;
      aux_eff = aux_source_select[mode_s];
      unique case (special_pin_function)
         FN_DIS_MAIN: main_dis = pin_s;
         FN_DIS_AUX: aux_dis = pin_s;
         FN_DIS_BOTH: begin
            main_dis = pin_s;
            aux_dis = pin_s;
         end
         FN_RMOD_EN: rmod_on = pin_s;
         FN_FORCE_AUX: begin
            if (pin_s) begin
               aux_eff = AUX_MAIN;
            end
         end
         FN_RSVD4, FN_RSVD5, FN_RSVD6: main_dis = 1'b0;
      endcase
   end

   // unlocked pll is blanked unless the output-on-unlock bit says otherwise
   assign pll_gated = pll_s && (locked_s || output_on_unlock_enable);
   assign next_main = pll_gated && !main_dis;

   // aux routing; the indicator is push-pull high or open-drain low on unlock
   always_comb begin
      next_aux = 1'b0;
      next_aux_oe = 1'b1;
      unique case (aux_eff)
         AUX_REF: next_aux = ref_s;
         AUX_RSVD: next_aux = 1'b0;
         AUX_MAIN: next_aux = pll_gated;
         AUX_UNLOCK: begin
            if (lock_indicator_config) begin
               next_aux_oe = !locked_s;
            end else begin
               next_aux = !locked_s;
            end
         end
      endcase
      if (aux_dis) begin
         next_aux = 1'b0;
         next_aux_oe = 1'b0;
      end
   end

   // 12.20 ratio of the active set, shifted only while the modifier is enabled
   assign next_ratio = rmod_on ? ratio_modify(ratio_set[mode_s], ratio_modifier_select[mode_s])
                               : ratio_set[mode_s];

   // outputs come straight from flops so a decode change cannot glitch a pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_out_o <= 1'b0;
         aux_out_o <= 1'b0;
         aux_out_oe_o <= 1'b0;
         ratio_o <= RST_RATIO;
      end else begin
         clk_out_o <= next_main;
         aux_out_o <= next_aux;
         aux_out_oe_o <= next_aux_oe;
         ratio_o <= next_ratio;
      end
   end

   sequence s_unlocked_blank;
      !locked_s && !output_on_unlock_enable;
   endsequence

   sequence s_pin_mod;
      special_pin_function == FN_RMOD_EN && pin_s;
   endsequence

   a_unlock_blank: assert property (@(posedge clk_i) disable iff (rst_i)
      s_unlocked_blank |=> !clk_out_o)
      else $error("main clock not held low while unlocked");
   a_unlock_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      output_on_unlock_enable && !main_dis |=> clk_out_o == $past(pll_s))
      else $error("main clock not passed through with output-on-unlock set");
   a_main_disable: assert property (@(posedge clk_i) disable iff (rst_i)
      (special_pin_function inside {FN_DIS_MAIN, FN_DIS_BOTH}) && pin_s |=> !clk_out_o)
      else $error("main clock not disabled by special pin");
   a_aux_disable: assert property (@(posedge clk_i) disable iff (rst_i)
      (special_pin_function inside {FN_DIS_AUX, FN_DIS_BOTH}) && pin_s |=> !aux_out_o && !aux_out_oe_o)
      else $error("aux output not disabled by special pin");
   a_ratio_mod: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pin_mod |=> ratio_o == ratio_modify($past(ratio_set[mode_s]), $past(ratio_modifier_select[mode_s])))
      else $error("ratio modifier not applied");
   a_ratio_plain: assert property (@(posedge clk_i) disable iff (rst_i)
      !(special_pin_function == FN_RMOD_EN && pin_s) |=> ratio_o == $past(ratio_set[mode_s]))
      else $error("ratio modified while not enabled");
   a_aux_force: assert property (@(posedge clk_i) disable iff (rst_i)
      special_pin_function == FN_FORCE_AUX && pin_s |=> aux_out_o == $past(pll_gated) && aux_out_oe_o)
      else $error("aux not forced to pll clock");
   a_rsvd_fn: assert property (@(posedge clk_i) disable iff (rst_i)
      (special_pin_function inside {FN_RSVD4, FN_RSVD5, FN_RSVD6}) && aux_eff == AUX_REF
      |=> clk_out_o == $past(pll_gated) && aux_out_o == $past(ref_s) && aux_out_oe_o)
      else $error("reserved pin function disturbed an output");
   a_aux_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
      aux_eff == AUX_UNLOCK && !aux_dis && !lock_indicator_config |=> aux_out_o == !$past(locked_s))
      else $error("push-pull unlock indicator wrong");
   a_ratio_store: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == OFS_RATIO0 && wb_sel_i == 4'hf |=> ratio_set[0] == $past(wb_dat_i) ##1 !wb_ack_o)
      else $error("ratio write not stored or ack held");
   a_global_store: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == OFS_GLOBAL && wb_sel_i[0] |=> global_word[6:0] == $past(wb_dat_i[6:0]))
      else $error("global set write not stored");
endmodule : synth_global_config_control

// ==== test/mode_pin_driver.sv ====
// system logic on the far side: mode pins, lock flag and clock levels
module mode_pin_driver (
   input wire logic clk_i,
   output logic [1:0] mode_select_o,
   output logic special_pin_o,
   output logic locked_o,
   output logic ref_clk_o,
   output logic pll_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ref_half = 0;
   int ref_cnt = 0;

   // every pin is driven from time zero, never left floating
   initial begin
      mode_select_o = 2'h0;
      special_pin_o = 1'b0;
      locked_o = 1'b1;
      ref_clk_o = 1'b0;
      pll_clk_o = 1'b1;
   end

   // a high special pin asks for the selected function, disable or enable alike; low releases it
   task automatic set_pins(input logic [1:0] m, input logic p, input logic l, input logic pc);
      @(posedge clk_i);
      mode_select_o <= m;
      special_pin_o <= p;
      locked_o <= l;
      pll_clk_o <= pc;
   endtask : set_pins

   // reference runs only while asked, so idle phases stay quiet
   always @(posedge clk_i) begin
      if (ref_half > 0) begin
         ref_cnt <= (ref_cnt + 1) % ref_half;
         if (ref_cnt == ref_half - 1) ref_clk_o <= ~ref_clk_o;
      end
   end
endmodule : mode_pin_driver

// ==== test/synth_global_config_control_bench.sv ====
module synth_global_config_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import synth_cfg_pkg::*;
   logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, q, rdat, ratio_o;
   logic [31:0] ratio_m[4], modal_m[4], glb_m;
   logic [1:0] msel;
   logic ack, pin, lock, refc, pllc, ref_div, clk_out, aux_out, aux_oe, prev;
   int failures = 0, checks = 0, seed = 74035, cnt, e;

   // 250 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   mode_pin_driver drv (.clk_i(clk_i), .mode_select_o(msel), .special_pin_o(pin), .locked_o(lock),
      .ref_clk_o(refc), .pll_clk_o(pllc));

   synth_global_config_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mode_select_i(msel), .special_mode_pin_i(pin), .pll_locked_i(lock), .ref_clk_i(refc),
      .pll_clk_i(pllc), .ref_div_clk_o(ref_div), .clk_out_o(clk_out), .aux_out_o(aux_out),
      .aux_out_oe_o(aux_oe), .ratio_o(ratio_o));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // one classic cycle; data taken at the edge that samples ack high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) begin
         failures++;
         summarize();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   // write through the bus and mirror it in the model
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      if (a < 8'h10) ratio_m[a[3:2]] = d;
      else if (a < 8'h20) modal_m[a[3:2]] = d & 32'hf;
      else if (a == 8'h20) glb_m = d & 32'h7f;
   endtask : wr

   initial begin
      for (int i = 0; i < 4; i++) begin
         ratio_m[i] = 32'h0010_0000;
         modal_m[i] = 32'h0;
      end
      glb_m = 32'h20;
      tick(10);
      rst_i <= 1'b0;
      tick(1);
      // reset contents of every set, then an unmapped word
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         check(q, (i < 4) ? ratio_m[i] : (i < 8) ? modal_m[i - 4] : glb_m);
      end
      bus(1'b0, 8'h40, 32'h0);
      check(q, 32'h0);
      // random ratios, one modifier code per set
      for (int i = 0; i < 4; i++) begin
         wr(8'(i * 4), $random(seed));
         wr(8'(8'h10 + i * 4), 32'(i));
      end
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         check(q, (i < 4) ? ratio_m[i] : modal_m[i - 4]);
      end
      // modifier only acts with the pin high
      wr(8'h20, 32'h23);
      for (int i = 0; i < 4; i++) begin
         drv.set_pins(2'(i), 1'b0, 1'b1, 1'b1);
         tick(5);
         check(ratio_o, ratio_m[i]);
         drv.set_pins(2'(i), 1'b1, 1'b1, 1'b1);
         tick(5);
         check(ratio_o, ratio_m[i] >> (i + 1));
         // the effective ratio word must agree with the ratio pins
         bus(1'b0, 8'h28, 32'h0);
         check(q, ratio_m[i] >> (i + 1));
      end
      for (int i = 0; i < 4; i++) wr(8'(8'h10 + i * 4), 32'h0);
      // disable mappings and the reserved codes
      for (int f = 0; f < 7; f++) begin
         wr(8'h20, 32'(8'h20 | f));
         drv.set_pins(2'h0, 1'b1, 1'b1, 1'b1);
         tick(5);
         check(32'(clk_out), 32'(!(f == 0 || f == 2)));
         check(32'(aux_oe), 32'(!(f == 1 || f == 2)));
         drv.set_pins(2'h0, 1'b0, 1'b1, 1'b1);
         tick(5);
         check(32'({clk_out, aux_oe}), 32'h3);
      end
      // gating while unlocked, without then with the output-on-unlock bit
      for (int u = 0; u < 2; u++) begin
         wr(8'h20, 32'(8'h20 | (u << 3)));
         drv.set_pins(2'h0, 1'b0, 1'b0, 1'b1);
         tick(5);
         check(32'(clk_out), 32'(u));
      end
      // forced aux source, then each programmed source
      for (int s = 0; s < 4; s++) begin
         wr(8'h10, 32'(s << 2));
         wr(8'h20, 32'h27);
         drv.set_pins(2'h0, 1'b1, 1'b1, 1'b1);
         tick(5);
         bus(1'b0, 8'h24, 32'h0);
         check(32'(q[5:4]), 32'h2);
         check(32'(q[3:0]), 32'h3);
         check(32'(aux_out), 32'h1);
         drv.set_pins(2'h0, 1'b0, 1'b1, 1'b1);
         tick(5);
         bus(1'b0, 8'h24, 32'h0);
         check(32'(q[5:4]), 32'(s));
         check(32'(q[3:0]), 32'h1);
         // reference is parked low and reserved drives low, so only source 10 shows a high
         check(32'(aux_out), 32'(s == 2));
      end
      // unlock indicator on aux: push-pull then open-drain, unlocked then locked
      for (int c = 0; c < 2; c++) begin
         wr(8'h20, 32'(8'h20 | (c << 6)));
         drv.set_pins(2'h0, 1'b0, 1'b0, 1'b1);
         tick(5);
         check(32'({aux_out, aux_oe}), (c == 0) ? 32'h3 : 32'h1);
         drv.set_pins(2'h0, 1'b0, 1'b1, 1'b1);
         tick(5);
         check(32'({aux_out, aux_oe}), (c == 0) ? 32'h1 : 32'h0);
      end
      // divider: count divided rises over 16 reference periods
      drv.ref_half = 4;
      for (int d = 0; d < 4; d++) begin
         wr(8'h20, 32'(d << 4));
         tick(8);
         e = (d == 3) ? 0 : (16 >> (2 - d));
         cnt = 0;
         prev = ref_div;
         repeat (128) begin
            @(posedge clk_i);
            if (ref_div === 1'b1 && prev === 1'b0) cnt++;
            prev = ref_div;
         end
         check(32'((e == 0) ? cnt == 0 : (cnt >= e - 1 && cnt <= e + 1)), 32'h1);
      end
      drv.ref_half = 0;
      summarize();
   end
endmodule : synth_global_config_control_bench
